/* rtl/wds_pkg.sv */
package wds_pkg;

  // Register indices; byte address is the index shifted by ADDR_SHIFT
  localparam logic [7:0] IDX_CTRL_MAIN = 8'h34;
  localparam logic [7:0] IDX_KEY_CODE  = 8'h35;
  localparam logic [7:0] IDX_STATUS    = 8'h38;
  localparam int         ADDR_SHIFT    = 2;
  localparam logic [9:0] BYTE_CTRL_MAIN = {IDX_CTRL_MAIN, 2'h0};
  localparam logic [9:0] BYTE_KEY_CODE  = {IDX_KEY_CODE, 2'h0};
  localparam logic [9:0] BYTE_STATUS    = {IDX_STATUS, 2'h0};

  // Key codes accepted by watchdog_key_code
  localparam logic [7:0] KEY_CLEAR   = 8'h4e;
  localparam logic [7:0] KEY_DISABLE = 8'hb1;
  localparam logic [7:0] KEY_TRAP    = 8'hd2;

  // watchdog_control_main fields
  localparam int         CTRL_W        = 6;
  localparam int         BIT_OVF_SEL   = 0;
  localparam int         TIME_LSB      = 1;
  localparam int         TIME_MSB      = 2;
  localparam int         BIT_ENABLE    = 3;
  localparam int         BIT_TRAP_ACT  = 4;
  localparam int         BIT_TRAP_AREA = 5;
  localparam logic [5:0] CTRL_RESET    = 6'h39;

  // Time base: divider tap for setting 00, step per setting
  localparam int         HI_BASE_EXP = 23;
  localparam int         LO_BASE_EXP = 15;
  localparam int         EXP_STEP    = 2;
  localparam logic [1:0] BIN_MAX     = 2'h3;

  // Reset pin low time, in high-frequency clock periods
  localparam logic [4:0] RESET_FC_TICKS = 5'h18;

  localparam int         STATUS_W = 11;
  localparam int         DATA_W   = 32;

  typedef enum logic [1:0] {
    WDS_OFF   = 2'h0,
    WDS_RUN   = 2'h1,
    WDS_RESET = 2'h3
  } wds_state_t;

endpackage

/* rtl/wds_counter.sv */
`timescale 1ns/1ps
module wds_counter #(
  parameter int DIV_W  = wds_pkg::HI_BASE_EXP,
  parameter int HI_EXP = wds_pkg::HI_BASE_EXP,
  parameter int LO_EXP = wds_pkg::LO_BASE_EXP
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       fc_tick,
  input  wire logic       fs_tick,
  input  wire logic       use_low,
  input  wire logic       hold,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [1:0] time_sel,
  output logic            overflow,
  output logic [1:0]      bin_count
);

  logic [DIV_W-1:0] div_reg;
  logic [1:0]       bin_reg;
  logic             adv;
  logic             tap_hit;
  logic [DIV_W-1:0] mask;

  function automatic logic [DIV_W-1:0] tap_mask(input logic low,
                                                 input logic [1:0] sel);
    int k;
    k = (low ? LO_EXP : HI_EXP) - wds_pkg::EXP_STEP * int'(sel);
    tap_mask = DIV_W'((64'h1 << k) - 64'h1);
  endfunction

  // Counting stops in stop, warm-up, idle and sleep
  assign adv      = clk_en && !hold && (use_low ? fs_tick : fc_tick);
  assign mask     = tap_mask(use_low, time_sel);
  assign tap_hit  = adv && ((div_reg & mask) == mask);
  // Wraps through zero so a kept-alive interrupt timer repeats
  assign overflow = run && !clear && tap_hit
                    && (bin_reg == wds_pkg::BIN_MAX);
  assign bin_count = bin_reg;

  // Divider is never cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (adv) begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_reg <= '0;
    end else if (clk_en) begin
      if (clear || !run) begin
        bin_reg <= '0;
      end else if (tap_hit) begin
        bin_reg <= bin_reg + 2'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  clear_keeps_div_a: assert property (
    clk_en && clear |=> bin_reg == 2'h0
      && div_reg == $past(div_reg) + DIV_W'($past(adv)))
    else $error("Clear must zero the binary counter only");

  hold_freezes_a: assert property (
    clk_en && hold && !clear && run |=> $stable(div_reg)
      && $stable(bin_reg))
    else $error("Counter moved while held");

  off_cleared_a: assert property (
    clk_en && !run |=> bin_reg == 2'h0)
    else $error("Binary counter not cleared while disabled");

endmodule

/* rtl/wds_top.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Watchdog runs right after reset release
// - Action defaults to reset, interrupt once
// - Action select cannot return to reset
// - Overflow with reset action pulls reset low
// - Overflow with interrupt action raises interrupt
// - Counting holds in stop, idle, sleep
// - Clear code zeroes counter, divider runs
// - Time field selects one of four periods
// - Main control reads undefined, never modify
// - Disable code works only with enable clear
// - Key codes: clear, disable, trap commit
// - Main control resets to enable, reset action
// - Overflow usable as periodic interrupt
// - Disabled watchdog holds counter cleared
// - Watchdog interrupt is non-maskable
module wds_top #(
  parameter int ADDR_W = 10,
  parameter int DIV_W  = wds_pkg::HI_BASE_EXP,
  parameter int HI_EXP = wds_pkg::HI_BASE_EXP,
  parameter int LO_EXP = wds_pkg::LO_BASE_EXP
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [wds_pkg::DATA_W-1:0] pwdata,
  output logic [wds_pkg::DATA_W-1:0]     prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      fc_tick,
  input  wire logic                      fs_tick,
  input  wire logic                      divider_stage_clock_select,
  input  wire logic                      slow_mode,
  input  wire logic                      stop_mode,
  input  wire logic                      warmup,
  input  wire logic                      idle_mode,
  output logic                           watchdog_overflow_irq,
  output logic                           sys_reset_req,
  output logic                           reset_pin_out,
  output logic                           reset_pin_oe,
  output logic                           trap_area_enable,
  output logic                           trap_action_reset
);

  logic [wds_pkg::CTRL_W-1:0] ctrl_reg;
  logic [wds_pkg::CTRL_W-1:0] ctrl_next;
  wds_pkg::wds_state_t        state_reg;
  wds_pkg::wds_state_t        state_next;
  logic [wds_pkg::DATA_W-1:0] prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic                       irq_reg;
  logic                       pin_out_reg;
  logic                       pin_oe_reg;
  logic                       trap_area_reg;
  logic [4:0]                 rst_cnt_reg;
  logic                       setup;
  logic                       access;
  logic                       wr_main;
  logic                       wr_key;
  logic [7:0]                 key;
  logic                       key_clear;
  logic                       ovf;
  logic                       run;
  logic                       rst_done;
  logic [1:0]                 bin_count;
  logic [wds_pkg::STATUS_W-1:0] status;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0] byte_addr);
    hit = (a == ADDR_W'(byte_addr));
  endfunction

  assign setup  = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign key    = pwdata[7:0];
  assign wr_main = access && pwrite && hit(paddr, wds_pkg::BYTE_CTRL_MAIN);
  assign wr_key  = access && pwrite && hit(paddr, wds_pkg::BYTE_KEY_CODE);
  assign key_clear = wr_key && (key == wds_pkg::KEY_CLEAR);
  assign run      = (state_reg == wds_pkg::WDS_RUN);
  assign rst_done = fc_tick
                    && (rst_cnt_reg == wds_pkg::RESET_FC_TICKS - 5'h1);

  // Status: reset active, count, running, trap commit, then control
  assign status = {state_reg == wds_pkg::WDS_RESET, bin_count, run,
                   trap_area_reg, ctrl_reg};

  wds_counter #(
    .DIV_W  (DIV_W),
    .HI_EXP (HI_EXP),
    .LO_EXP (LO_EXP)
  ) u_counter (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .fc_tick   (fc_tick),
    .fs_tick   (fs_tick),
    .use_low   (divider_stage_clock_select || slow_mode),
    .hold      (stop_mode || warmup || idle_mode),
    .run       (run),
    .clear     (key_clear),
    .time_sel  (ctrl_reg[wds_pkg::TIME_MSB:wds_pkg::TIME_LSB]),
    .overflow  (ovf),
    .bin_count (bin_count)
  );

  // Registered in the setup phase so every bus output comes from a flop with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else if (clk_en) begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= !(hit(paddr, wds_pkg::BYTE_CTRL_MAIN)
                         || hit(paddr, wds_pkg::BYTE_KEY_CODE)
                         || hit(paddr, wds_pkg::BYTE_STATUS));
        // Write-only registers read as zero
        if (!pwrite && hit(paddr, wds_pkg::BYTE_STATUS)) begin
          prdata_reg <= wds_pkg::DATA_W'(status);
        end else begin
          prdata_reg <= '0;
        end
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (state_reg == wds_pkg::WDS_RESET && rst_done) begin
      ctrl_next = wds_pkg::CTRL_RESET;
    end else if (wr_main) begin
      ctrl_next = pwdata[wds_pkg::CTRL_W-1:0];
      // Once interrupt action is chosen it sticks
      ctrl_next[wds_pkg::BIT_OVF_SEL] = ctrl_reg[wds_pkg::BIT_OVF_SEL]
        && pwdata[wds_pkg::BIT_OVF_SEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= wds_pkg::CTRL_RESET;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_area_reg <= 1'b1;
    end else if (clk_en) begin
      if (state_reg == wds_pkg::WDS_RESET && rst_done) begin
        trap_area_reg <= 1'b1;
      end else if (wr_key && key == wds_pkg::KEY_TRAP) begin
        trap_area_reg <= ctrl_reg[wds_pkg::BIT_TRAP_AREA];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wds_pkg::WDS_OFF: begin
        if (wr_main && pwdata[wds_pkg::BIT_ENABLE]) begin
          state_next = wds_pkg::WDS_RUN;
        end
      end
      wds_pkg::WDS_RUN: begin
        if (ovf && ctrl_reg[wds_pkg::BIT_OVF_SEL]) begin
          state_next = wds_pkg::WDS_RESET;
        end else if (wr_key && key == wds_pkg::KEY_DISABLE
                     && !ctrl_reg[wds_pkg::BIT_ENABLE]) begin
          state_next = wds_pkg::WDS_OFF;
        end
      end
      wds_pkg::WDS_RESET: begin
        // Internal state except the divider restarts as after a power-on reset
        if (rst_done) begin
          state_next = wds_pkg::WDS_RUN;
        end
      end
      default: begin
        state_next = wds_pkg::WDS_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= wds_pkg::WDS_RUN;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Pin low time is counted on the high-frequency clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg != wds_pkg::WDS_RESET) begin
        rst_cnt_reg <= '0;
      end else if (fc_tick) begin
        rst_cnt_reg <= rst_cnt_reg + 5'h1;
      end
    end
  end

  // No mask: the request reaches the CPU whatever its flag says
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= ovf && !ctrl_reg[wds_pkg::BIT_OVF_SEL];
    end
  end

  // Open-drain pin: only ever drives low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
    end else if (clk_en) begin
      pin_out_reg <= 1'b0;
      // Tracks the state flop so the pin comes from its own flop
      pin_oe_reg  <= (state_next == wds_pkg::WDS_RESET);
    end
  end

  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;
  assign watchdog_overflow_irq = irq_reg;
  assign sys_reset_req         = pin_oe_reg;
  assign reset_pin_oe          = pin_oe_reg;
  assign reset_pin_out         = pin_out_reg;
  assign trap_area_enable      = trap_area_reg;
  assign trap_action_reset     = ctrl_reg[wds_pkg::BIT_TRAP_ACT];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  start_running_a: assert property (
    !$past(presetn) |-> run && ctrl_reg[wds_pkg::BIT_OVF_SEL])
    else $error("Watchdog not running with reset action after reset");

  ctrl_reset_a: assert property (
    !$past(presetn) |-> ctrl_reg == wds_pkg::CTRL_RESET)
    else $error("Main control reset value wrong");

  action_lock_a: assert property (
    !ctrl_reg[wds_pkg::BIT_OVF_SEL] |=> !ctrl_reg[wds_pkg::BIT_OVF_SEL])
    else $error("Action select returned to reset");

  ovf_reset_a: assert property (
    clk_en && ovf && ctrl_reg[wds_pkg::BIT_OVF_SEL]
      |=> reset_pin_oe && sys_reset_req && !reset_pin_out && !irq_reg)
    else $error("Overflow did not pull reset low");

  ovf_irq_a: assert property (
    clk_en && ovf && !ctrl_reg[wds_pkg::BIT_OVF_SEL]
      |=> irq_reg && (run || $past(wr_key)) && !reset_pin_oe)
    else $error("Overflow did not raise interrupt");

  irq_cause_a: assert property (
    irq_reg && $past(clk_en) |-> $past(ovf) && (run || $past(wr_key)))
    else $error("Interrupt without overflow or counter stopped");

  disable_guard_a: assert property (
    wr_key && key == wds_pkg::KEY_DISABLE && run
      && ctrl_reg[wds_pkg::BIT_ENABLE] && !ovf |=> run)
    else $error("Disable code acted with enable set");

  invalid_key_a: assert property (
    wr_key && key != wds_pkg::KEY_DISABLE && key != wds_pkg::KEY_TRAP
      && run && !ovf |=> run && $stable(trap_area_reg))
    else $error("Invalid key code had an effect");

  read_main_a: assert property (
    clk_en && setup && !pwrite && hit(paddr, wds_pkg::BYTE_CTRL_MAIN)
      |=> prdata == '0 ##1 !pready)
    else $error("Main control read not zero");

  pin_release_a: assert property (
    reset_pin_oe && rst_done && clk_en |=> !reset_pin_oe && run)
    else $error("Reset pin not released after its time");

  reset_seen_c: cover property (clk_en && ovf
                                && ctrl_reg[wds_pkg::BIT_OVF_SEL]);
  irq_seen_c: cover property (irq_reg ##[1:1000] irq_reg);
  disabled_c: cover property (state_reg == wds_pkg::WDS_OFF);
  cleared_c: cover property (key_clear && bin_count != 2'h0);

endmodule

/* test/watchdog_supervisor_test.sv */
`timescale 1ns/1ps
module watchdog_supervisor_test;
  localparam int HI = 8;
  localparam int LO = 6;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fc_tick;
  logic        fs_tick;
  logic        divider_stage_clock_select;
  logic        slow_mode;
  logic        stop_mode;
  logic        warmup;
  logic        idle_mode;
  logic        watchdog_overflow_irq;
  logic        sys_reset_req;
  logic        reset_pin_out;
  logic        reset_pin_oe;
  logic        trap_area_enable;
  logic        trap_action_reset;
  int          cyc;
  int          errors;
  int          compares;
  int          irq_q[$];
  logic [31:0] seed;
  logic [31:0] rv;
  int          t0;
  int          k;
  int          w;

  wds_top #(.DIV_W(HI), .HI_EXP(HI), .LO_EXP(LO)) uut (.*);

  always #5 pclk = ~pclk;

  // Timestamps on the falling edge, where registered outputs are settled
  always @(negedge pclk) begin
    cyc++;
    if (watchdog_overflow_irq === 1'b1) irq_q.push_back(cyc);
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    compares++;
    if (v < lo || v > hi) begin
      errors++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, v);
    end
  endtask

  task automatic apb(input logic wr_n, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, data and error are taken at the completing rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("BAD pready exp 1 got %b", pready);
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper data bits are noise the register must ignore
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    seed = nxt(seed);
    apb(1'b1, a, {seed[31:8], d}, q, e);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] q,
                    output logic e);
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wait_q(input int n, input int lim);
    int i;
    i = 0;
    while (irq_q.size() < n && i < lim) begin
      @(negedge pclk);
      i++;
    end
    if (irq_q.size() < n) begin
      errors++;
      $display("BAD irq_count exp %0d got %0d", n, irq_q.size());
      wrap_up();
    end
  endtask

  task automatic gap(input int e);
    irq_q.delete();
    wait_q(3, 5 * e + 50);
    chk("irq_gap", e, irq_q[2] - irq_q[1]);
  endtask

  task automatic bad_codes();
    logic [7:0] c;
    repeat (4) begin
      seed = nxt(seed);
      c = seed[7:0];
      if (c != 8'h4e && c != 8'hb1 && c != 8'hd2) begin
        wr(wds_pkg::BYTE_KEY_CODE, c);
      end
    end
  endtask

  initial begin
    logic e;
    pclk = 0;
    presetn = 0;
    clk_en = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    fc_tick = 1;
    fs_tick = 0;
    slow_mode = 0;
    divider_stage_clock_select = 0;
    stop_mode = 0;
    warmup = 0;
    idle_mode = 0;
    cyc = 0;
    errors = 0;
    compares = 0;
    seed = 32'h4931;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    rd(wds_pkg::BYTE_STATUS, rv, e);
    chk("status", 32'h0f9, rv & 32'hfffffcff);
    rd(wds_pkg::BYTE_CTRL_MAIN, rv, e);
    chk("ctrl_read", 32'h0, rv);
    rd(10'h3fc, rv, e);
    chk("unmapped_err", 1, e);
    w = 0;
    while (reset_pin_oe !== 1'b1 && w < 1500) begin
      @(negedge pclk);
      w++;
    end
    rng("reset_time", 1020, 1030, cyc - t0);
    chk("reset_pin", 2'b10, {sys_reset_req, reset_pin_out});
    w = 0;
    while (reset_pin_oe === 1'b1 && w < 100) begin
      @(negedge pclk);
      w++;
    end
    rng("reset_width", 24, 25, w);
    rd(wds_pkg::BYTE_STATUS, rv, e);
    chk("status_after", 32'h0f9, rv & 32'hfffffcff);
    for (int src = 0; src < 3; src++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge pclk);
        divider_stage_clock_select <= (src == 1);
        slow_mode <= (src == 2);
        fc_tick <= (src == 0);
        fs_tick <= (src != 0);
        wr(wds_pkg::BYTE_CTRL_MAIN, {4'h3, s[1:0], 1'b0} | 8'h08);
        k = (src == 0 ? HI : LO) - 2 * s;
        gap(4 << k);
      end
    end
    @(posedge pclk);
    divider_stage_clock_select <= 1'b0;
    slow_mode <= 1'b0;
    fc_tick <= 1'b1;
    fs_tick <= 1'b0;
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h3f);
    gap(16);
    chk("no_reset", 0, reset_pin_oe);
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h38);
    irq_q.delete();
    wait_q(1, 1100);
    while (cyc < irq_q[0] + 600) @(negedge pclk);
    wr(wds_pkg::BYTE_KEY_CODE, 8'h4e);
    rd(wds_pkg::BYTE_STATUS, rv, e);
    chk("count_clear", 0, rv[9:8]);
    wait_q(2, 1200);
    rng("clear_gap", 1533, 1539, irq_q[1] - irq_q[0]);
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h3e);
    for (int m = 0; m < 4; m++) begin
      irq_q.delete();
      wait_q(1, 100);
      // Stop and warm-up are bracketed by clears, so the gap grows
      if (m < 2) begin
        wr(wds_pkg::BYTE_KEY_CODE, 8'h4e);
      end else begin
        @(posedge pclk);
      end
      if (m == 0) stop_mode <= 1'b1;
      if (m == 1) warmup <= 1'b1;
      if (m == 2) idle_mode <= 1'b1;
      if (m == 3) clk_en <= 1'b0;
      repeat (100) @(posedge pclk);
      stop_mode <= 1'b0;
      warmup <= 1'b0;
      idle_mode <= 1'b0;
      clk_en <= 1'b1;
      if (m < 2) wr(wds_pkg::BYTE_KEY_CODE, 8'h4e);
      wait_q(2, 100);
      k = (m < 2) ? 120 : 116;
      rng("hold_gap", k - 1, k + 1, irq_q[1] - irq_q[0]);
    end
    wr(wds_pkg::BYTE_KEY_CODE, 8'hb1);
    gap(16);
    wr(wds_pkg::BYTE_KEY_CODE, 8'h4e);
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h36);
    bad_codes();
    rd(wds_pkg::BYTE_STATUS, rv, e);
    chk("running", 1, rv[7]);
    // Disable just after a pulse so no overflow shares its edge
    irq_q.delete();
    wait_q(1, 100);
    wr(wds_pkg::BYTE_KEY_CODE, 8'hb1);
    irq_q.delete();
    repeat (200) @(negedge pclk);
    chk("irq_off", 0, irq_q.size());
    rd(wds_pkg::BYTE_STATUS, rv, e);
    chk("status_off", 32'h076, rv);
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h3e);
    gap(16);
    wr(wds_pkg::BYTE_CTRL_MAIN, 8'h0e);
    repeat (2) @(negedge pclk);
    chk("trap_pending", 2'b10, {trap_area_enable, trap_action_reset});
    wr(wds_pkg::BYTE_KEY_CODE, 8'hd2);
    repeat (2) @(negedge pclk);
    chk("trap_commit", 0, trap_area_enable);
    wrap_up();
  end
endmodule
